// ### include/irxc_pkg.sv
// irxc_pkg: offsets, field layout and reset values for the receive
// context interrupt event/enable block.
// assumes an apb slave with 32-bit data and byte addresses.
`default_nettype none
package irxc_pkg;
  // number of receive contexts
  localparam int unsigned NUM_CTX = 4;
  // register byte offsets
  localparam logic [7:0] OFF_EVENT_SET = 8'ha0;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'ha4;
  localparam logic [7:0] OFF_ENABLE_SET = 8'ha8;
  localparam logic [7:0] OFF_ENABLE_CLEAR = 8'hac;
  // block-local control/status word
  localparam logic [7:0] OFF_CTRL = 8'hb0;
  // flag and enable field
  localparam int unsigned FLAG_LSB = 0;
  localparam int unsigned FLAG_MSB = 3;
  // control word: global gate bit
  localparam int unsigned GATE_BIT = 31;
  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic GATE_RST = 1'b0;
  // apb answers in one access cycle
  localparam int unsigned WAIT_CYCLES = 0;
endpackage
`default_nettype wire

// ### logic/irxc_edge.sv
// irxc_edge: per-context rising edge detector for the internal
// completion interrupt lines.
// assumes the lines are synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module irxc_edge #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  // state: last sampled level
  typedef struct packed {
    logic [WIDTH-1:0] last;
  } irxc_edge_state_t;

  irxc_edge_state_t state;
  irxc_edge_state_t next_state;

  // rise only on a low to high step, so a held line counts once
  assign rise = level & ~state.last;

  // next state
  always_comb begin
    next_state = state;
    next_state.last = level;
  end

  // registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// ### logic/irxc_regs.sv
// irxc_regs: sticky event flags and enables of four receive
// contexts, apb register slave, summary and external interrupt.
// assumes apb master with 32-bit data; completion pulses arrive
// synchronous to core_clk from the receive dma engines.
`timescale 1ns/10ps
`default_nettype none
module irxc_regs #(
  parameter int unsigned NCTX = irxc_pkg::NUM_CTX
) (
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // completion of a receive command, qualified by its interrupt bits
  input wire logic [NCTX-1:0] cmd_done,
  input wire logic [NCTX-1:0] cmd_int_bits,
  // interrupt outputs
  output logic rx_summary_interrupt,
  output logic irq
);
  // all state of this module
  typedef struct packed {
    logic [NCTX-1:0] rx_context_event_flags; // sticky flags
    logic [NCTX-1:0] rx_context_enable_bits; // per-context enables
    logic global_interrupt_gate; // gate for external irq
    logic [31:0] rdata; // registered read data
    logic ready; // access phase answer
    logic slverr; // unmapped address
    logic summary; // registered summary
    logic irq; // registered external irq
  } irxc_state_t;

  irxc_state_t state;
  irxc_state_t next_state;

  // internal interrupt line per context
  logic [NCTX-1:0] ctx_int_line;
  // asserting edge of each line
  logic [NCTX-1:0] ctx_int_rise;

  // a completion only counts with its interrupt bits set
  assign ctx_int_line = cmd_done & cmd_int_bits;

  // edge detector so a held line sets the flag once
  irxc_edge #(
    .WIDTH(NCTX)
  ) u_edge (
    .core_clk(core_clk),
    .nrst(nrst),
    .level(ctx_int_line),
    .rise(ctx_int_rise)
  );

  // zero-extend a context field into a bus word
  function automatic logic [31:0] widen(input logic [NCTX-1:0] v);
    logic [31:0] w;
    w = '0;
    w[NCTX-1:0] = v;
    return w;
  endfunction

  // mapped address check
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == irxc_pkg::OFF_EVENT_SET) ||
      (a == irxc_pkg::OFF_EVENT_CLEAR) ||
      (a == irxc_pkg::OFF_ENABLE_SET) ||
      (a == irxc_pkg::OFF_ENABLE_CLEAR) ||
      (a == irxc_pkg::OFF_CTRL);
  endfunction

  // apb handshake qualifiers
  logic setup_ph;
  logic wr_acc;
  logic [NCTX-1:0] wmask;
  logic [NCTX-1:0] pend;

  assign setup_ph = psel && !penable;
  // write takes effect at the completing access edge
  assign wr_acc = psel && penable && state.ready && pwrite;
  assign wmask = pwdata[NCTX-1:0];
  // pending = raised and enabled; read path and summary share it
  assign pend = state.rx_context_event_flags &
    state.rx_context_enable_bits;

  // next state: flags, enables, bus answer, interrupts
  always_comb begin
    next_state = state;
    next_state.ready = 1'b0;
    next_state.slverr = 1'b0;
    // clear first, then set, so a same-cycle event wins
    if (wr_acc && paddr == irxc_pkg::OFF_EVENT_CLEAR) begin
      next_state.rx_context_event_flags =
        state.rx_context_event_flags & ~wmask;
    end
    if (wr_acc && paddr == irxc_pkg::OFF_EVENT_SET) begin
      next_state.rx_context_event_flags =
        next_state.rx_context_event_flags | wmask;
    end
    // hardware edges or-ed in last: no write can hide them
    next_state.rx_context_event_flags =
      next_state.rx_context_event_flags | ctx_int_rise;
    // enables: ones act, zeros leave alone
    if (wr_acc && paddr == irxc_pkg::OFF_ENABLE_SET) begin
      next_state.rx_context_enable_bits =
        state.rx_context_enable_bits | wmask;
    end
    if (wr_acc && paddr == irxc_pkg::OFF_ENABLE_CLEAR) begin
      next_state.rx_context_enable_bits =
        state.rx_context_enable_bits & ~wmask;
    end
    if (wr_acc && paddr == irxc_pkg::OFF_CTRL) begin
      next_state.global_interrupt_gate = pwdata[irxc_pkg::GATE_BIT];
    end
    // setup cycle prepares the answer for the access cycle
    if (setup_ph) begin
      next_state.ready = 1'b1;
      next_state.slverr = !is_mapped(paddr);
      next_state.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          irxc_pkg::OFF_EVENT_SET: begin
            next_state.rdata =
              widen(state.rx_context_event_flags);
          end
          irxc_pkg::OFF_EVENT_CLEAR: begin
            next_state.rdata = widen(pend);
          end
          irxc_pkg::OFF_ENABLE_SET,
          irxc_pkg::OFF_ENABLE_CLEAR: begin
            next_state.rdata =
              widen(state.rx_context_enable_bits);
          end
          irxc_pkg::OFF_CTRL: begin
            next_state.rdata[irxc_pkg::GATE_BIT] =
              state.global_interrupt_gate;
          end
          default: begin
            // unmapped: zero data with error
            next_state.rdata = '0;
          end
        endcase
      end
    end
    // summary names the cause, gate blocks the pin
    next_state.summary = |pend;
    next_state.irq = (|pend) && state.global_interrupt_gate;
  end

  // registers; enables reset to zero so upper bits stay zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state.rx_context_event_flags <= irxc_pkg::FLAGS_RST;
      state.rx_context_enable_bits <= irxc_pkg::ENABLE_RST;
      state.global_interrupt_gate <= irxc_pkg::GATE_RST;
      state.rdata <= '0;
      state.ready <= 1'b0;
      state.slverr <= 1'b0;
      state.summary <= 1'b0;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  // irq lags a gate write by one cycle, just like the summary
  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign rx_summary_interrupt = state.summary;
  assign irq = state.irq;

  // ---- assertions ----
  // they only watch signals; nothing here drives logic
  property p_edge_sets;
    @(posedge core_clk) disable iff (!nrst)
      ctx_int_rise[0] |=> state.rx_context_event_flags[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set flag");

  property p_done_needs_bits;
    @(posedge core_clk) disable iff (!nrst)
      (cmd_done[1] && !cmd_int_bits[1] && !$past(ctx_int_line[1])
       && !state.rx_context_event_flags[1] && !wr_acc)
      |=> !state.rx_context_event_flags[1];
  endproperty
  a_done_needs_bits: assert property (p_done_needs_bits)
    else $error("flag set without interrupt bits");

  property p_set_write;
    @(posedge core_clk) disable iff (!nrst)
      (wr_acc && paddr == irxc_pkg::OFF_EVENT_SET && pwdata[2])
      |=> state.rx_context_event_flags[2];
  endproperty
  a_set_write: assert property (p_set_write)
    else $error("set write failed");

  property p_only_clear;
    @(posedge core_clk) disable iff (!nrst)
      (state.rx_context_event_flags[0] &&
       !(wr_acc && paddr == irxc_pkg::OFF_EVENT_CLEAR && pwdata[0]))
      |=> state.rx_context_event_flags[0];
  endproperty
  a_only_clear: assert property (p_only_clear)
    else $error("flag lost without clear");

  property p_clear_read;
    @(posedge core_clk) disable iff (!nrst)
      (setup_ph && !pwrite && paddr == irxc_pkg::OFF_EVENT_CLEAR)
      |=> prdata == widen($past(pend));
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("clear address read wrong");

  property p_raw_read;
    @(posedge core_clk) disable iff (!nrst)
      (setup_ph && !pwrite && paddr == irxc_pkg::OFF_EVENT_SET)
      |=> prdata == widen($past(state.rx_context_event_flags));
  endproperty
  a_raw_read: assert property (p_raw_read)
    else $error("set address read wrong");

  property p_enable_clear;
    @(posedge core_clk) disable iff (!nrst)
      (wr_acc && paddr == irxc_pkg::OFF_ENABLE_CLEAR && pwdata[3])
      |=> !state.rx_context_enable_bits[3];
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("enable clear failed");

  property p_summary;
    @(posedge core_clk) disable iff (!nrst)
      (|pend) |=> rx_summary_interrupt;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary missing");

  property p_gate;
    @(posedge core_clk) disable iff (!nrst)
      !$past(state.global_interrupt_gate) |-> !irq;
  endproperty
  a_gate: assert property (p_gate)
    else $error("irq while gate clear");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!nrst)
      (setup_ph && !pwrite && paddr != irxc_pkg::OFF_CTRL)
      |=> prdata[31:NCTX] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits nonzero");

  property p_edge_sets_top;
    @(posedge core_clk) disable iff (!nrst)
      ctx_int_rise[3] |=> state.rx_context_event_flags[3];
  endproperty
  a_edge_sets_top: assert property (p_edge_sets_top)
    else $error("edge did not set top flag");

  // a line held high must not raise a cleared flag again
  property p_held_once;
    @(posedge core_clk) disable iff (!nrst)
      ($past(nrst) && $past(ctx_int_line[2]) && ctx_int_line[2]
       && !state.rx_context_event_flags[2]
       && !(wr_acc && paddr == irxc_pkg::OFF_EVENT_SET && pwdata[2]))
      |=> !state.rx_context_event_flags[2];
  endproperty
  a_held_once: assert property (p_held_once)
    else $error("held line set flag twice");

  property p_enable_set;
    @(posedge core_clk) disable iff (!nrst)
      (wr_acc && paddr == irxc_pkg::OFF_ENABLE_SET && pwdata[1])
      |=> state.rx_context_enable_bits[1];
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("enable set failed");

  // zero bits in the write word leave their enable alone
  property p_enable_keep;
    @(posedge core_clk) disable iff (!nrst)
      (wr_acc && paddr == irxc_pkg::OFF_ENABLE_SET && !pwdata[0])
      |=> state.rx_context_enable_bits[0] ==
        $past(state.rx_context_enable_bits[0]);
  endproperty
  a_enable_keep: assert property (p_enable_keep)
    else $error("enable changed by zero bit");

  property p_enable_read;
    @(posedge core_clk) disable iff (!nrst)
      (setup_ph && !pwrite && (paddr == irxc_pkg::OFF_ENABLE_SET ||
       paddr == irxc_pkg::OFF_ENABLE_CLEAR))
      |=> prdata == widen($past(state.rx_context_enable_bits));
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable read wrong");

  property p_summary_low;
    @(posedge core_clk) disable iff (!nrst)
      !(|pend) |=> !rx_summary_interrupt;
  endproperty
  a_summary_low: assert property (p_summary_low)
    else $error("summary without cause");

  property p_irq_on;
    @(posedge core_clk) disable iff (!nrst)
      ((|pend) && state.global_interrupt_gate) |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("irq missing with gate open");

  // every setup is answered in the very next cycle
  property p_ready_next;
    @(posedge core_clk) disable iff (!nrst)
      setup_ph |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no answer after setup");
endmodule
`default_nettype wire

// ### sim/irxc_dma_model.sv
// irxc_dma_model: stands in for the receive dma engines that
// report command completion with its interrupt bits.
// assumes fire/want_int come from the bench on core_clk.
`timescale 1ns/10ps
`default_nettype none
module irxc_dma_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] fire, // command of context n completes
  input wire logic [3:0] want_int, // that command asks an interrupt
  output logic [3:0] cmd_done,
  output logic [3:0] cmd_int_bits
);
  // both lines leave one edge late and together, so the device
  // sees the interrupt bits and their completion as the bench drove them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_done <= 4'h0;
      cmd_int_bits <= 4'h0;
    end else begin
      cmd_done <= fire;
      cmd_int_bits <= want_int;
    end
  end
endmodule
`default_nettype wire

// ### sim/iso_rx_context_interrupt_regs_tb.sv
// iso_rx_context_interrupt_regs_tb: apb tests of the receive
// context event and enable registers and both interrupts.
// assumes irxc_regs with its default four contexts.
`timescale 1ns/10ps
`default_nettype none
module iso_rx_context_interrupt_regs_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_summary_interrupt, irq;
  logic [3:0] fire = 4'h0;
  logic [3:0] want_int = 4'h0;
  logic [3:0] cmd_done, cmd_int_bits;
  logic [31:0] rd; // last read word
  logic er; // last slave error
  int num_errors = 0;
  int checked = 0;
  // 25 MHz core clock
  always #20 core_clk = ~core_clk;
  irxc_dma_model u_dma (.core_clk(core_clk), .nrst(nrst),
    .fire(fire), .want_int(want_int), .cmd_done(cmd_done),
    .cmd_int_bits(cmd_int_bits));
  irxc_regs u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_done(cmd_done),
    .cmd_int_bits(cmd_int_bits),
    .rx_summary_interrupt(rx_summary_interrupt), .irq(irq));
  // one apb transfer; waits for pready, the watchdog bounds it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // pready is read before this edge's own updates land
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // read a register and compare its word
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read word", e, rd);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog far beyond the roughly 140 cycles the tests take
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(8'ha0, 32'h0);
    rchk(8'ha8, 32'h0);
    // software set, upper data bits must not show
    apb(1'b1, 8'ha0, 32'hffffffff);
    rchk(8'ha0, 32'h0000000f);
    rchk(8'ha4, 32'h0);
    chk("summary", 32'h0, {31'h0, rx_summary_interrupt});
    // enables through set and clear addresses
    apb(1'b1, 8'ha8, 32'hfffffff5);
    rchk(8'hac, 32'h00000005);
    apb(1'b1, 8'hac, 32'h00000001);
    rchk(8'ha8, 32'h00000004);
    rchk(8'ha4, 32'h00000004);
    chk("summary", 32'h1, {31'h0, rx_summary_interrupt});
    chk("irq gated", 32'h0, {31'h0, irq});
    // clearing enables or reading does not clear flags
    apb(1'b1, 8'hac, 32'h0000000f);
    rchk(8'ha4, 32'h0);
    rchk(8'ha0, 32'h0000000f);
    apb(1'b1, 8'ha4, 32'h00000003);
    rchk(8'ha0, 32'h0000000c);
    // gate open, summary and irq follow flag and enable
    apb(1'b1, 8'hb0, 32'h80000000);
    apb(1'b1, 8'ha8, 32'h00000008);
    rchk(8'ha0, 32'h0000000c);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 8'ha4, 32'h00000008);
    rchk(8'ha0, 32'h00000004);
    chk("summary", 32'h0, {31'h0, rx_summary_interrupt});
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 8'ha4, 32'h0000000f);
    // hardware completion per context, held high
    for (int n = 0; n < 4; n++) begin
      fire <= 4'h1 << n;
      rchk(8'ha0, 32'h0);
      want_int <= 4'h1 << n;
      // the model adds one edge and the flag one more before a read
      @(posedge core_clk);
      rchk(8'ha0, 32'h1 << n);
      apb(1'b1, 8'ha4, 32'h1 << n);
      rchk(8'ha0, 32'h0);
      fire <= 4'h0;
      want_int <= 4'h0;
      // let the lines fall before the next context fires
      @(posedge core_clk);
    end
    // unmapped place refuses and keeps state
    apb(1'b1, 8'hc0, 32'hffffffff);
    chk("slverr", 32'h1, {31'h0, er});
    rchk(8'hc0, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    rchk(8'ha0, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
